// [rf_aux_pin_control.sv]
// auxiliary output pin control: antenna switch, front-end indicator, rx time stamp
// assumes register port and radio status on mclk_i; sleep_tx_trigger_i is a raw pin
`timescale 1ns/1ps
module rf_aux_pin_control
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    output logic [7:0] reg_rdata_o,
    // radio core status
    input wire logic [2:0] trx_state_i,
    input wire logic rx_start_i,
    input wire logic rx_end_i,
    input wire logic [1:0] amplifier_lead_time_i,
    // transmit trigger pin
    input wire logic sleep_tx_trigger_i,
    // transmit sequencing
    output logic tx_request_o,
    output logic modulation_start_o,
    // auxiliary pins
    output logic aux_pin_one_o,
    output logic aux_pin_two_o,
    output logic aux_pin_three_o,
    output logic aux_pin_four_o
);

    typedef enum logic [1:0]
    {
        FE_IDLE,
        FE_LEAD,
        FE_ACTIVE
    } fe_phase_t;

    typedef struct packed
    {
        logic [7:0] radio_misc_control;
        logic [7:0] antenna_switch_control;
        logic [1:0] applied_sel;
        logic trig_meta;
        logic trig_sync;
        logic trig_prev;
        logic [2:0] prev_state;
        logic stamp;
        logic tx_req;
        logic [aux_pin_pkg::TIMER_W-1:0] mod_cnt;
        logic mod_start;
        fe_phase_t fe_phase;
        logic pin_one;
        logic pin_two;
        logic pin_three;
        logic pin_four;
        logic [7:0] rdata;
    } ctrl_state_t;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    logic timer_start;
    logic timer_expired;
    logic [aux_pin_pkg::TIMER_W-1:0] timer_load;

    // differential antenna pattern {pin one, pin two}
    function automatic logic [1:0] antenna_pattern(input logic [1:0] sel);
        logic [1:0] pat;
        pat = 2'h0;
        if (sel == aux_pin_pkg::ANT_SEL_ANT0)
        begin
            pat = 2'h1;
        end
        else if (sel == aux_pin_pkg::ANT_SEL_ANT1)
        begin
            pat = 2'h2;
        end
        return pat;
    endfunction

    // states in which a new antenna select reaches the pins
    function automatic logic select_window(input logic [2:0] st);
        return (st == aux_pin_pkg::STATE_PLL_ON) || (st == aux_pin_pkg::STATE_RX_ON);
    endfunction

    // indicator delay after tx entry, earlier for a longer lead
    function automatic logic [aux_pin_pkg::TIMER_W-1:0] lead_delay(input logic [1:0] lt);
        logic [aux_pin_pkg::TIMER_W-1:0] steps;
        steps = aux_pin_pkg::TIMER_W'({lt} + 3'h1);
        return aux_pin_pkg::TIMER_W'(aux_pin_pkg::SYMBOL_CYCLES - steps * aux_pin_pkg::LEAD_STEP_CYCLES);
    endfunction

    logic ant_en;
    logic stamp_en;
    logic fe_en;
    logic in_tx;
    logic was_tx;
    logic trig_rise;
    logic [1:0] ant_pat;

    assign ant_en = s_reg.antenna_switch_control[aux_pin_pkg::ANT_SW_EN_BIT];
    assign stamp_en = s_reg.radio_misc_control[aux_pin_pkg::TIMESTAMP_EN_BIT];
    assign fe_en = s_reg.radio_misc_control[aux_pin_pkg::FRONT_END_EN_BIT];
    assign in_tx = (trx_state_i == aux_pin_pkg::STATE_BUSY_TX);
    assign was_tx = (s_reg.prev_state == aux_pin_pkg::STATE_BUSY_TX);
    assign trig_rise = s_reg.trig_sync & ~s_reg.trig_prev;
    assign ant_pat = antenna_pattern(s_reg.applied_sel);
    assign timer_start = in_tx & ~was_tx;
    assign timer_load = lead_delay(amplifier_lead_time_i);

    lead_delay_timer u_lead_timer
    (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .start_i(timer_start),
        .load_i(timer_load),
        .expired_o(timer_expired)
    );

    always_comb
    begin
        s_next = s_reg;

        // trigger pin synchroniser and edge history
        s_next.trig_meta = sleep_tx_trigger_i;
        s_next.trig_sync = s_reg.trig_meta;
        s_next.trig_prev = s_reg.trig_sync;
        s_next.prev_state = trx_state_i;

        // register writes
        if (reg_write_i && reg_addr_i == aux_pin_pkg::RADIO_MISC_CONTROL_ADDR)
            s_next.radio_misc_control = reg_wdata_i;
        if (reg_write_i && reg_addr_i == aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR)
            s_next.antenna_switch_control = reg_wdata_i & aux_pin_pkg::ANTENNA_SWITCH_CONTROL_MASK;

        // register reads, unmapped reads as zero
        if (reg_addr_i == aux_pin_pkg::RADIO_MISC_CONTROL_ADDR)
            s_next.rdata = s_reg.radio_misc_control;
        else if (reg_addr_i == aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR)
            s_next.rdata = s_reg.antenna_switch_control;
        else
            s_next.rdata = 8'h00;

        // select reaches the pins only in pll-on or rx-on
        if (select_window(trx_state_i))
            s_next.applied_sel = s_reg.antenna_switch_control[aux_pin_pkg::ANT_SEL_MSB:aux_pin_pkg::ANT_SEL_LSB];

        // time stamp: a start in the same cycle as an end wins
        if (!stamp_en)
            s_next.stamp = 1'b0;
        else if (rx_start_i)
            s_next.stamp = 1'b1;
        else if (rx_end_i)
            s_next.stamp = 1'b0;

        // trigger edge from pll-on requests tx, modulation one symbol later
        s_next.tx_req = trig_rise && (trx_state_i == aux_pin_pkg::STATE_PLL_ON);
        s_next.mod_start = 1'b0;
        if (s_next.tx_req)
        begin
            s_next.mod_cnt = aux_pin_pkg::SYMBOL_CYCLES;
        end
        else if (s_reg.mod_cnt != aux_pin_pkg::TIMER_ZERO)
        begin
            s_next.mod_cnt = s_reg.mod_cnt - aux_pin_pkg::TIMER_ONE;
            s_next.mod_start = (s_reg.mod_cnt == aux_pin_pkg::TIMER_ONE);
        end

        // front-end indicator phase
        unique case (s_reg.fe_phase)
            FE_IDLE:
                if (timer_start)
                    s_next.fe_phase = FE_LEAD;
            FE_LEAD:
                if (!in_tx)
                    s_next.fe_phase = FE_IDLE;
                else if (was_tx && timer_expired)
                    s_next.fe_phase = FE_ACTIVE;
            FE_ACTIVE:
                if (!in_tx)
                    s_next.fe_phase = FE_IDLE;
            default:
                s_next.fe_phase = FE_IDLE;
        endcase

        // pin one: antenna or ground, in every state while enabled
        s_next.pin_one = ant_en ? ant_pat[1] : 1'b0;

        // pin two: stamp has priority, then antenna, else ground
        if (stamp_en)
        begin
            s_next.pin_two = s_next.stamp;
        end
        else if (ant_en)
        begin
            s_next.pin_two = ant_pat[0];
        end
        else
        begin
            s_next.pin_two = 1'b0;
        end

        // pins three/four: tx indicator or ground
        if (!fe_en)
        begin
            s_next.pin_three = 1'b0;
            s_next.pin_four = 1'b0;
        end
        else
        begin
            s_next.pin_three = (s_next.fe_phase == FE_ACTIVE);
            s_next.pin_four = (s_next.fe_phase != FE_ACTIVE);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            s_reg <= '0;
            s_reg.radio_misc_control <= aux_pin_pkg::RADIO_MISC_CONTROL_RESET;
            s_reg.antenna_switch_control <= aux_pin_pkg::ANTENNA_SWITCH_CONTROL_RESET;
            s_reg.applied_sel <= aux_pin_pkg::ANT_SEL_RESET;
            s_reg.fe_phase <= FE_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_o = s_reg.rdata;
    assign tx_request_o = s_reg.tx_req;
    assign modulation_start_o = s_reg.mod_start;
    assign aux_pin_one_o = s_reg.pin_one;
    assign aux_pin_two_o = s_reg.pin_two;
    assign aux_pin_three_o = s_reg.pin_three;
    assign aux_pin_four_o = s_reg.pin_four;

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_ant_only;
        ant_en && !stamp_en;
    endsequence

    sequence s_stamp_start;
        stamp_en && rx_start_i;
    endsequence

    sequence s_stamp_end;
        stamp_en && rx_end_i && !rx_start_i;
    endsequence

    property p_ant_zero;
        s_ant_only and (s_reg.applied_sel == aux_pin_pkg::ANT_SEL_ANT0) |=> !aux_pin_one_o && aux_pin_two_o;
    endproperty
    a_ant_zero: assert property (p_ant_zero) else $error("antenna zero pattern wrong");

    property p_ant_one;
        s_ant_only and (s_reg.applied_sel == aux_pin_pkg::ANT_SEL_ANT1) |=> aux_pin_one_o && !aux_pin_two_o;
    endproperty
    a_ant_one: assert property (p_ant_one) else $error("antenna one pattern wrong");

    property p_ant_sleep;
        ant_en && (trx_state_i == aux_pin_pkg::STATE_SLEEP)
            && (s_reg.applied_sel == aux_pin_pkg::ANT_SEL_ANT1) |=> aux_pin_one_o;
    endproperty
    a_ant_sleep: assert property (p_ant_sleep) else $error("antenna output dropped in sleep");

    property p_split;
        ant_en && stamp_en |=> (aux_pin_two_o == s_reg.stamp)
            && (aux_pin_one_o == $past(s_reg.applied_sel == aux_pin_pkg::ANT_SEL_ANT1));
    endproperty
    a_split: assert property (p_split) else $error("pin two not stamping");

    property p_ant_off;
        !ant_en |=> !aux_pin_one_o;
    endproperty
    a_ant_off: assert property (p_ant_off) else $error("pin one not grounded");

    property p_pin_two_ground;
        !ant_en && !stamp_en |=> !aux_pin_two_o;
    endproperty
    a_pin_two_ground: assert property (p_pin_two_ground) else $error("pin two not grounded");

    property p_reserved_sel;
        ant_en && !stamp_en && (s_reg.applied_sel != aux_pin_pkg::ANT_SEL_ANT0)
            && (s_reg.applied_sel != aux_pin_pkg::ANT_SEL_ANT1) |=> !aux_pin_one_o && !aux_pin_two_o;
    endproperty
    a_reserved_sel: assert property (p_reserved_sel) else $error("reserved select drives pin");

    property p_sel_hold;
        !select_window(trx_state_i) |=> $stable(s_reg.applied_sel);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select applied outside window");

    property p_stamp_rise;
        s_stamp_start |=> aux_pin_two_o ##1 (aux_pin_two_o || !stamp_en || rx_end_i || $past(rx_end_i));
    endproperty
    a_stamp_rise: assert property (p_stamp_rise) else $error("stamp did not rise");

    property p_stamp_fall;
        s_stamp_end |=> !aux_pin_two_o;
    endproperty
    a_stamp_fall: assert property (p_stamp_fall) else $error("stamp did not fall");

    property p_fe_off;
        !fe_en |=> !aux_pin_three_o && !aux_pin_four_o;
    endproperty
    a_fe_off: assert property (p_fe_off) else $error("front-end pins not grounded");

    property p_fe_not_tx;
        fe_en && !in_tx |=> !aux_pin_three_o && aux_pin_four_o;
    endproperty
    a_fe_not_tx: assert property (p_fe_not_tx) else $error("indicator wrong outside tx");

    property p_fe_entry;
        $rose(aux_pin_three_o) |-> $past(timer_expired) && $past(was_tx);
    endproperty
    a_fe_entry: assert property (p_fe_entry) else $error("indicator ignored lead delay");

    property p_mod_load;
        tx_request_o |=> s_reg.mod_cnt == aux_pin_pkg::SYMBOL_CYCLES - aux_pin_pkg::TIMER_ONE;
    endproperty
    a_mod_load: assert property (p_mod_load) else $error("symbol count not started");

    property p_mod_fire;
        modulation_start_o |-> $past(s_reg.mod_cnt) == aux_pin_pkg::TIMER_ONE;
    endproperty
    a_mod_fire: assert property (p_mod_fire) else $error("modulation start mistimed");

endmodule

// [aux_pin_pkg.sv]
// constants for the auxiliary pin control block
// assumes a 40 MHz mclk_i and transceiver state codes from the radio core
package aux_pin_pkg;

    // register map
    localparam logic [7:0] RADIO_MISC_CONTROL_ADDR = 8'h04;
    localparam logic [7:0] ANTENNA_SWITCH_CONTROL_ADDR = 8'h0d;
    localparam logic [7:0] RADIO_MISC_CONTROL_RESET = 8'h20;
    localparam logic [7:0] ANTENNA_SWITCH_CONTROL_RESET = 8'h01;
    localparam logic [7:0] ANTENNA_SWITCH_CONTROL_MASK = 8'h07;

    // field positions
    localparam int FRONT_END_EN_BIT = 7;
    localparam int TIMESTAMP_EN_BIT = 6;
    localparam int ANT_SW_EN_BIT = 2;
    localparam int ANT_SEL_MSB = 1;
    localparam int ANT_SEL_LSB = 0;

    // antenna select encodings
    localparam logic [1:0] ANT_SEL_ANT0 = 2'h1;
    localparam logic [1:0] ANT_SEL_ANT1 = 2'h2;
    localparam logic [1:0] ANT_SEL_RESET = 2'h1;

    // transceiver state codes seen on trx_state_i
    localparam logic [2:0] STATE_SLEEP = 3'h0;
    localparam logic [2:0] TRANSCEIVER_OFF_STATE = 3'h1;
    localparam logic [2:0] STATE_PLL_ON = 3'h2;
    localparam logic [2:0] STATE_RX_ON = 3'h3;
    localparam logic [2:0] STATE_BUSY_RX = 3'h4;
    localparam logic [2:0] STATE_BUSY_TX = 3'h5;

    // timing
    localparam int MCLK_MHZ = 40;
    localparam int SYMBOL_NS = 16000;
    localparam int LEAD_STEP_NS = 2000;
    localparam int TIMER_W = 10;
    localparam logic [TIMER_W-1:0] SYMBOL_CYCLES = TIMER_W'(SYMBOL_NS * MCLK_MHZ / 1000);
    localparam logic [TIMER_W-1:0] LEAD_STEP_CYCLES = TIMER_W'(LEAD_STEP_NS * MCLK_MHZ / 1000);
    localparam logic [TIMER_W-1:0] TIMER_ONE = 10'h001;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 10'h000;

endpackage

// [lead_delay_timer.sv]
// down counter timing the front-end indicator lead
// assumes load_i is at least one and start_i is a single-cycle pulse
`timescale 1ns/1ps
module lead_delay_timer
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // control
    input wire logic start_i,
    input wire logic [aux_pin_pkg::TIMER_W-1:0] load_i,
    // status
    output logic expired_o
);

    typedef struct packed
    {
        logic [aux_pin_pkg::TIMER_W-1:0] count;
    } timer_state_t;

    timer_state_t s_reg;
    timer_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (start_i)
        begin
            s_next.count = load_i;
        end
        else if (s_reg.count != aux_pin_pkg::TIMER_ZERO)
        begin
            s_next.count = s_reg.count - aux_pin_pkg::TIMER_ONE;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign expired_o = (s_reg.count == aux_pin_pkg::TIMER_ZERO);

endmodule

// [aux_far_side.sv]
// far-side model: antenna switch, front-end switch and timer capture
// assumes registered pin levels from the aux pin block on mclk_i
`timescale 1ns/1ps
module aux_far_side
(
    // clock
    input wire logic mclk_i,
    // auxiliary pins
    input wire logic aux_pin_one_i,
    input wire logic aux_pin_two_i,
    input wire logic aux_pin_three_i,
    input wire logic aux_pin_four_i,
    // observed far-side state
    output logic [1:0] antenna_o,
    output logic pa_on_o,
    output logic [7:0] capture_count_o
);
    logic pin_two_last = 1'b0;
    logic [7:0] captures = 8'h00;

    assign capture_count_o = captures;

    // one leg high picks an antenna, both low picks none
    assign antenna_o = {aux_pin_one_i & ~aux_pin_two_i, ~aux_pin_one_i & aux_pin_two_i};
    assign pa_on_o = aux_pin_three_i & ~aux_pin_four_i;

    // timer capture counts rising edges on pin two
    always_ff @(posedge mclk_i)
    begin
        if (aux_pin_two_i && !pin_two_last)
            captures <= captures + 8'h01;
        pin_two_last <= aux_pin_two_i;
    end
endmodule

// [rf_aux_pin_control_tb.sv]
// self-checking bench for the auxiliary pin control block
// assumes the aux pin package and the far-side model are compiled first
`timescale 1ns/1ps
module rf_aux_pin_control_tb;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic [2:0] trx_state_i = aux_pin_pkg::TRANSCEIVER_OFF_STATE;
    logic rx_start_i = 1'b0;
    logic rx_end_i = 1'b0;
    logic [1:0] amplifier_lead_time_i = 2'h0;
    logic sleep_tx_trigger_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic tx_request_o;
    logic modulation_start_o;
    logic aux_pin_one_o;
    logic aux_pin_two_o;
    logic aux_pin_three_o;
    logic aux_pin_four_o;
    logic [1:0] antenna;
    logic pa_on;
    logic [7:0] capture_count;
    logic [7:0] c;
    int n_mismatch = 0;
    int total_checks = 0;
    int n;
    int d;
    int l;

    always #12.5 mclk_i = ~mclk_i;

    rf_aux_pin_control u_dut
    (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i),
        .reg_rdata_o(reg_rdata_o),
        .trx_state_i(trx_state_i),
        .rx_start_i(rx_start_i),
        .rx_end_i(rx_end_i),
        .amplifier_lead_time_i(amplifier_lead_time_i),
        .sleep_tx_trigger_i(sleep_tx_trigger_i),
        .tx_request_o(tx_request_o),
        .modulation_start_o(modulation_start_o),
        .aux_pin_one_o(aux_pin_one_o),
        .aux_pin_two_o(aux_pin_two_o),
        .aux_pin_three_o(aux_pin_three_o),
        .aux_pin_four_o(aux_pin_four_o)
    );

    aux_far_side u_far
    (
        .mclk_i(mclk_i),
        .aux_pin_one_i(aux_pin_one_o),
        .aux_pin_two_i(aux_pin_two_o),
        .aux_pin_three_i(aux_pin_three_o),
        .aux_pin_four_i(aux_pin_four_o),
        .antenna_o(antenna),
        .pa_on_o(pa_on),
        .capture_count_o(capture_count)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge mclk_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_addr_i <= a;
        cyc(2);
        check(16'(reg_rdata_o), 16'(exp));
    endtask

    task automatic state(input logic [2:0] s);
        @(posedge mclk_i);
        trx_state_i <= s;
    endtask

    // pins as {one, two, three, four} once settled
    task automatic pins(input logic [3:0] exp);
        cyc(3);
        check(16'({aux_pin_one_o, aux_pin_two_o, aux_pin_three_o, aux_pin_four_o}), 16'(exp));
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        pins(4'h0);
        rd(aux_pin_pkg::RADIO_MISC_CONTROL_ADDR, 8'h20);
        rd(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h01);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'hff);
        rd(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h07);
        $display("test registers done");
        pins(4'h4);
        state(aux_pin_pkg::STATE_PLL_ON);
        pins(4'h0);
        for (int s = 1; s < 3; s++)
        begin
            wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h04 | 8'(s));
            pins({s == 2, s == 1, 2'b00});
        end
        check(16'(antenna), 16'h0002);
        state(aux_pin_pkg::STATE_SLEEP);
        pins(4'h8);
        state(aux_pin_pkg::TRANSCEIVER_OFF_STATE);
        wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h05);
        pins(4'h8);
        state(aux_pin_pkg::STATE_RX_ON);
        pins(4'h4);
        check(16'(antenna), 16'h0001);
        wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h01);
        pins(4'h0);
        $display("test antenna done");
        wr(aux_pin_pkg::RADIO_MISC_CONTROL_ADDR, 8'ha0);
        pins(4'h1);
        for (int lt = 0; lt < 4; lt++)
        begin
            state(aux_pin_pkg::STATE_PLL_ON);
            amplifier_lead_time_i <= 2'(lt);
            @(posedge mclk_i);
            sleep_tx_trigger_i <= 1'b1;
            n = 0;
            while (tx_request_o !== 1'b1 && n < 10)
            begin
                cyc(1);
                n++;
            end
            check(16'(tx_request_o), 16'h0001);
            state(aux_pin_pkg::STATE_BUSY_TX);
            sleep_tx_trigger_i <= 1'b0;
            n = 1;
            d = 0;
            while (modulation_start_o !== 1'b1 && n < 1000)
            begin
                cyc(1);
                n++;
                if (d == 0 && aux_pin_three_o === 1'b1)
                    d = n;
            end
            l = int'(aux_pin_pkg::SYMBOL_CYCLES) - (lt + 1) * int'(aux_pin_pkg::LEAD_STEP_CYCLES);
            check(16'(n), 16'h0280);
            check(16'(d >= l + 1 && d <= l + 6), 16'h0001);
            check(16'(pa_on), 16'h0001);
            state(aux_pin_pkg::STATE_RX_ON);
            pins(4'h1);
        end
        wr(aux_pin_pkg::RADIO_MISC_CONTROL_ADDR, 8'h20);
        pins(4'h0);
        $display("test front end done");
        wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h06);
        wr(aux_pin_pkg::RADIO_MISC_CONTROL_ADDR, 8'h60);
        pins(4'h8);
        c = capture_count;
        @(posedge mclk_i);
        rx_start_i <= 1'b1;
        @(posedge mclk_i);
        rx_start_i <= 1'b0;
        #1;
        check(16'(aux_pin_two_o), 16'h0001);
        cyc(20);
        check(16'({aux_pin_one_o, aux_pin_two_o}), 16'h0003);
        @(posedge mclk_i);
        rx_end_i <= 1'b1;
        @(posedge mclk_i);
        rx_end_i <= 1'b0;
        #1;
        check(16'(aux_pin_two_o), 16'h0000);
        check(16'(capture_count), 16'(c + 8'h01));
        wr(aux_pin_pkg::RADIO_MISC_CONTROL_ADDR, 8'h20);
        wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h05);
        pins(4'h4);
        wr(aux_pin_pkg::ANTENNA_SWITCH_CONTROL_ADDR, 8'h01);
        pins(4'h0);
        $display("test time stamp done");
        give_verdict();
    end

    // watchdog well past the longest expected run
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        give_verdict();
    end
endmodule
